//--- core/fpc_pkg.sv
// Package for the fixed-ratio synthesizer core: ratios, widths, counts.
// Assumes a single 50 MHz system clock domain.
package fpc_pkg;

  // ***********************************************************************
  // Divider widths and ratios
  // ***********************************************************************
  localparam int unsigned FB_CNT_W    = 10;
  localparam int unsigned REF_CNT_W   = 6;
  localparam int unsigned FB_RATIO_A  = 725;
  localparam int unsigned FB_RATIO_B  = 550;
  localparam int unsigned FB_RATIO_C  = 750;
  localparam int unsigned REF_RATIO_A = 64;
  localparam int unsigned REF_RATIO_C = 128;

  // ***********************************************************************
  // Lock detection and clock
  // ***********************************************************************
  localparam int unsigned LOCK_CLEAN_CYCLES = 4;
  localparam int unsigned LOCK_CNT_W        = 3;
  localparam int unsigned CLK_PERIOD_NS     = 20;

  // ***********************************************************************
  // Phase detector state
  // ***********************************************************************
  typedef enum logic [1:0] {
    FPC_PD_IDLE = 2'b00,
    FPC_PD_UP   = 2'b01,
    FPC_PD_DOWN = 2'b10
  } fpc_pd_state_t;

endpackage

//--- core/fpc_divider.sv
// Edge-qualified divide-by-N counter with synchronous clear.
// Assumes the input is already synchronous to clock.
`timescale 1ns/10ps
`default_nettype none

module fpc_divider #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned RATIO = 725
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Control
  input  wire logic clear,
  input  wire logic in_level,
  // Divided output
  output logic      div_pulse,
  output logic      div_level
);

  logic [WIDTH-1:0] cnt_ff;
  logic             prev_ff;
  logic             rise;
  logic [WIDTH:0]   ratio_m1;
  logic             at_end;

  assign rise     = in_level & ~prev_ff;
  assign ratio_m1 = (WIDTH+1)'(RATIO - 1);
  assign at_end   = ({1'b0, cnt_ff} == ratio_m1);

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prev_ff <= 1'b0;
    else
      prev_ff <= in_level;
  end

  // Counter restarts from zero together with its peer after a clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cnt_ff <= '0;
    else if (clear)
      cnt_ff <= '0;
    else if (rise)
    begin
      if (at_end)
        cnt_ff <= '0;
      else
        cnt_ff <= cnt_ff + WIDTH'(1);
    end
  end

  // Terminal pulse on wrap; level output is high while the count is below (RATIO-1)/2
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      div_pulse <= 1'b0;
    else
      div_pulse <= ~clear & rise & at_end;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      div_level <= 1'b0;
    else
      div_level <= ~clear & ({1'b0, cnt_ff} < (ratio_m1 >> 1));
  end

endmodule // fpc_divider

`default_nettype wire

//--- core/fpc_core.sv
// Fixed-ratio synthesizer digital core: dividers, phase detector, lock,
// standby control and analog switch control.
// Assumes fin and rin are digitised and synchronous to clock.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Feedback input divided by a 10-bit binary counter into the comparator.
// - Reference input divided by a 6-bit binary counter (7-bit for ratio 128) into the comparator.
// - Ratios fixed per variant: 64/725, 64/550 or 128/750, no programming.
// - Lock indicator high while locked, low while out of lock.
// - Power-save select high means active; low means standby, circuits idle.
// - Standby indicator low in standby; rises after reference signal seen.
// - On wake-up both divided clocks are forced into the same phase.
// - Three-state charge pump output follows reference/feedback relation.
// - Test input pulled down so open pin means normal operation; the code has no pull-down and uses test_mode as driven.
// - Switch-control input governs the on-chip analog switches.
// - Pump high when reference leads, low when lags, floats at match.
// - Lock after four clean comparisons; drops at once on phase error.
// - Lock indicator forced high while power-save select is low.
// - Switch-control high closes all analog switches; low opens them.
module fpc_core #(
  parameter int unsigned REF_RATIO = fpc_pkg::REF_RATIO_A,
  parameter int unsigned FB_RATIO  = fpc_pkg::FB_RATIO_A
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Signal inputs
  input  wire logic fin,
  input  wire logic rin,
  // Controller pins
  input  wire logic low_power_select,
  input  wire logic switch_control,
  input  wire logic test_mode,
  // Charge pump
  output logic      pump_out,
  output logic      pump_oe,
  // Indicators
  output logic      lock_indicator,
  output logic      standby_indicator,
  // Analog switches
  output logic      analog_switch_one,
  output logic      analog_switch_two,
  // Divided clocks
  output logic      divided_reference_clock,
  output logic      divided_feedback_clock
);

  // ***********************************************************************
  // Mode control
  // ***********************************************************************
  logic active_ff;
  logic rin_prev_ff;
  logic ref_seen_ff;
  logic hold_clear;
  logic test_active;
  logic r_pulse;
  logic v_pulse;

  // Test pin acts when driven high; there is no pull-down, so an open pin floats and is not read as low
  assign test_active = test_mode;
  assign hold_clear  = ~low_power_select | test_active;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      active_ff <= 1'b0;
    else
      active_ff <= low_power_select;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rin_prev_ff <= 1'b0;
    else
      rin_prev_ff <= rin;
  end

  // Sticky until standby is selected again
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      ref_seen_ff <= 1'b0;
    else if (!low_power_select)
      ref_seen_ff <= 1'b0;
    else if (active_ff && rin && !rin_prev_ff)
      ref_seen_ff <= 1'b1;
  end

  assign standby_indicator = ref_seen_ff;

  // ***********************************************************************
  // Dividers
  // ***********************************************************************
  // Never narrower than the base width; widens for larger ratios
  function automatic int unsigned cnt_width(input int unsigned base,
                                            input int unsigned ratio);
    int unsigned need;
    need = $clog2(ratio);
    return (need > base) ? need : base;
  endfunction

  // Shared clear keeps both counters in phase on wake-up
  fpc_divider #(
    .WIDTH (cnt_width(fpc_pkg::REF_CNT_W, REF_RATIO)),
    .RATIO (REF_RATIO)
  ) u_ref_div (
    .clock     (clock),
    .nrst      (nrst),
    .clear     (hold_clear),
    .in_level  (rin),
    .div_pulse (r_pulse),
    .div_level (divided_reference_clock)
  );

  fpc_divider #(
    .WIDTH (cnt_width(fpc_pkg::FB_CNT_W, FB_RATIO)),
    .RATIO (FB_RATIO)
  ) u_fb_div (
    .clock     (clock),
    .nrst      (nrst),
    .clear     (hold_clear),
    .in_level  (fin),
    .div_pulse (v_pulse),
    .div_level (divided_feedback_clock)
  );

  // ***********************************************************************
  // Phase detector
  // ***********************************************************************
  fpc_pkg::fpc_pd_state_t pd_ff;
  logic                   compare_done;

  // Coincident edges mean matched phase; no pulse is produced
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      pd_ff <= fpc_pkg::FPC_PD_IDLE;
    else if (hold_clear)
      pd_ff <= fpc_pkg::FPC_PD_IDLE;
    else
    begin
      unique case (pd_ff)
        fpc_pkg::FPC_PD_IDLE:
          if (r_pulse && !v_pulse)
            pd_ff <= fpc_pkg::FPC_PD_UP;
          else if (v_pulse && !r_pulse)
            pd_ff <= fpc_pkg::FPC_PD_DOWN;
        fpc_pkg::FPC_PD_UP:
          if (v_pulse)
            pd_ff <= fpc_pkg::FPC_PD_IDLE;
        fpc_pkg::FPC_PD_DOWN:
          if (r_pulse)
            pd_ff <= fpc_pkg::FPC_PD_IDLE;
        default:
          pd_ff <= fpc_pkg::FPC_PD_IDLE;
      endcase
    end
  end

  // Pulse width equals the phase difference
  assign pump_oe  = (pd_ff != fpc_pkg::FPC_PD_IDLE);
  assign pump_out = (pd_ff == fpc_pkg::FPC_PD_UP);

  // A comparison ends on each reference terminal pulse
  assign compare_done = r_pulse;

  // ***********************************************************************
  // Lock detector
  // ***********************************************************************
  logic [fpc_pkg::LOCK_CNT_W-1:0] clean_ff;
  logic                           err_seen_ff;
  logic                           locked_ff;
  logic                           phase_err;

  assign phase_err = pump_oe | (r_pulse ^ v_pulse);

  // Error flag spans one comparison period
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      err_seen_ff <= 1'b0;
    else if (compare_done)
      err_seen_ff <= phase_err;
    else if (phase_err)
      err_seen_ff <= 1'b1;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      clean_ff <= '0;
    else if (hold_clear || phase_err)
      clean_ff <= '0;
    else if (compare_done && !err_seen_ff &&
             clean_ff != fpc_pkg::LOCK_CNT_W'(fpc_pkg::LOCK_CLEAN_CYCLES))
      clean_ff <= clean_ff + fpc_pkg::LOCK_CNT_W'(1);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      locked_ff <= 1'b0;
    else if (hold_clear || phase_err)
      locked_ff <= 1'b0; // drops at once
    else if (clean_ff == fpc_pkg::LOCK_CNT_W'(fpc_pkg::LOCK_CLEAN_CYCLES))
      locked_ff <= 1'b1;
  end

  // Combinational so an error drops the indicator the same cycle
  assign lock_indicator = ~low_power_select
                        | (locked_ff & ~phase_err);

  // ***********************************************************************
  // Analog switches
  // ***********************************************************************
  assign analog_switch_one = switch_control;
  assign analog_switch_two = switch_control;

endmodule // fpc_core

`default_nettype wire

//--- sim/fpc_osc.sv
// Reference and feedback oscillator model for the core's signal inputs.
// Assumes the core samples rin and fin on the rising edge of clock.
`timescale 1ns/10ps
`default_nettype none

module fpc_osc #(
  parameter int unsigned REF_PER = 10
) (
  // Clock and control
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [3:0] fb_per,
  // Oscillator outputs
  output var logic        rin,
  output var logic        fin
);
  localparam logic [3:0] RL = 4'(REF_PER - 1);
  localparam logic [3:0] RH = 4'(REF_PER / 2 - 1);
  logic [3:0] rc_ff;
  logic [3:0] fc_ff;

  // Both stand low outside runs; first rise one full period after start
  always_ff @(posedge clock)
  begin
    rc_ff <= (!run || rc_ff == RL) ? 4'h0 : rc_ff + 4'h1;
    rin   <= run & ((rc_ff == RL) | (rin & (rc_ff != RH)));
  end

  always_ff @(posedge clock)
  begin
    fc_ff <= (!run || fc_ff == fb_per - 4'h1) ? 4'h0 : fc_ff + 4'h1;
    fin   <= run & ((fc_ff == fb_per - 4'h1)
             | (fin & (fc_ff != (fb_per >> 1) - 4'h1)));
  end
endmodule // fpc_osc

`default_nettype wire

//--- sim/fpc_core_asserts.sv
// Port checker for the synthesizer core.
// Bound to every fpc_core instance; single clock domain.
`timescale 1ns/10ps
`default_nettype none

module fpc_core_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Watched pins
  input wire logic low_power_select,
  input wire logic switch_control,
  input wire logic test_mode,
  input wire logic pump_out,
  input wire logic pump_oe,
  input wire logic lock_indicator,
  input wire logic standby_indicator,
  input wire logic analog_switch_one,
  input wire logic analog_switch_two,
  input wire logic divided_reference_clock,
  input wire logic divided_feedback_clock
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_asleep;
    !low_power_select ##1 !low_power_select;
  endsequence
  sequence s_wake;
    !low_power_select ##1 low_power_select;
  endsequence
  sequence s_test_held;
    test_mode ##1 test_mode;
  endsequence

  a_lock_forced: assert property (!low_power_select |-> lock_indicator)
    else $error("lock not forced high in standby");
  a_sleep_idle: assert property (s_asleep |-> !pump_oe)
    else $error("pump driven in standby");
  a_div_cleared: assert property (s_asleep |-> !divided_reference_clock
    && !divided_feedback_clock) else $error("dividers run in standby");
  a_wake_unlocked: assert property (s_wake |-> !lock_indicator)
    else $error("lock high right after wake");
  a_standby_low: assert property (!low_power_select |=> !standby_indicator)
    else $error("standby indicator high in standby");
  a_standby_rise: assert property ($rose(standby_indicator) |->
    $past(low_power_select)) else $error("standby indicator rose asleep");
  a_switch_follow: assert property (analog_switch_one == switch_control
    && analog_switch_two == switch_control) else $error("switch mismatch");
  a_pump_unlock: assert property (low_power_select && pump_oe |->
    !lock_indicator) else $error("lock high while pump drives");
  a_pump_steady: assert property (pump_oe && $past(pump_oe) |->
    $stable(pump_out)) else $error("pump direction changed in pulse");
  a_test_hold: assert property (s_test_held |-> !pump_oe
    && !divided_reference_clock && !divided_feedback_clock)
    else $error("dividers run in test mode");
endmodule // fpc_core_asserts

bind fpc_core fpc_core_asserts u_chk (.*);

`default_nettype wire

//--- sim/test_fixed_ratio_pll_core.sv
// Testbench for the synthesizer core with shortened ratios 4 and 5.
// Uses fpc_osc for rin and fin; pins change 1 ns after rising edges.
`timescale 1ns/10ps
`default_nettype none

module test_fixed_ratio_pll_core;
  localparam int unsigned RR = 4;
  localparam int unsigned FR = 5;
  localparam int unsigned RP = 10;
  logic       clock, nrst, lps, sw, run, pout, poe, lock, sbi, tm;
  logic       sw1, sw2, dref, dfb, rin, fin, seen_oe;
  logic [3:0] fper;
  int         miscompares, total_checks, cyc, t, p;

  fpc_osc #(.REF_PER(RP)) u_osc (.clock(clock), .run(run), .fb_per(fper),
    .rin(rin), .fin(fin));
  fpc_core #(.REF_RATIO(RR), .FB_RATIO(FR)) dut (.clock(clock), .nrst(nrst),
    .fin(fin), .rin(rin), .low_power_select(lps), .switch_control(sw),
    .test_mode(tm), .pump_out(pout), .pump_oe(poe), .lock_indicator(lock),
    .standby_indicator(sbi), .analog_switch_one(sw1),
    .analog_switch_two(sw2), .divided_reference_clock(dref),
    .divided_feedback_clock(dfb));

  task automatic chk(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    t = 0;
    while (s !== v && t < lim)
    begin
      tick(1);
      t++;
    end
  endtask
  // Sleeping first gives every wake a fresh, aligned start
  task automatic wake(input logic [3:0] per);
    lps = 1'b0;
    run = 1'b0;
    tick(3);
    fper = per;
    lps = 1'b1;
    run = 1'b1;
  endtask
  // Sync to a fresh rise first so p spans one whole period
  task automatic gap(ref logic s);
    wait_lvl(s, 1'b0, 100);
    wait_lvl(s, 1'b1, 100);
    wait_lvl(s, 1'b0, 100);
    p = t;
    wait_lvl(s, 1'b1, 100);
    p += t;
  endtask

  task automatic t_standby;
    tick(2);
    chk("lock", 1'b1, lock);
    chk("pump_oe", 1'b0, poe);
    chk("standby", 1'b0, sbi);
    chk("div_ref", 1'b0, dref);
    $display("test standby done");
  endtask
  task automatic t_wake;
    wake(4'h8);
    tick(1);
    chk("lock_wake", 1'b0, lock);
    wait_lvl(sbi, 1'b1, 20);
    chk("standby", 1'b1, sbi);
    gap(dref);
    chk("ref_period", 1'b1, p == RR * RP);
    gap(dfb);
    chk("fb_period", 1'b1, p == FR * 8);
    wait_lvl(lock, 1'b1, 300);
    chk("lock", 1'b1, lock);
    chk("seen_oe", 1'b0, seen_oe);
    $display("test wake done");
  endtask
  task automatic t_skew(input logic [3:0] per, input logic e);
    wake(per);
    wait_lvl(poe, 1'b1, 100);
    chk("pump_oe", 1'b1, poe);
    chk("pump_out", e, pout);
    chk("lock", 1'b0, lock);
    $display("test skew done");
  endtask
  task automatic t_test;
    wake(4'h8);
    tm = 1'b1;
    tick(60);
    chk("test_ref", 1'b0, dref);
    chk("test_fb", 1'b0, dfb);
    chk("test_pump", 1'b0, seen_oe);
    tm = 1'b0;
    $display("test test_mode done");
  endtask
  task automatic t_switch;
    for (int v = 0; v < 2; v++)
    begin
      sw = 1'(v);
      tick(1);
      chk("switch_one", 1'(v), sw1);
      chk("switch_two", 1'(v), sw2);
    end
    $display("test switch done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
  begin
    // Standby clears the record, so each wake starts clean
    seen_oe <= lps & (seen_oe | (poe === 1'b1));
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      end_sim();
    end
  end
  // Power-up with standby selected, as the controller must do
  initial
  begin
    {nrst, lps, sw, run, tm} = '0;
    fper = 4'h8;
    tick(8);
    nrst = 1'b1;
    t_standby();
    t_wake();
    t_skew(4'h7, 1'b0);
    t_skew(4'h9, 1'b1);
    t_test();
    t_switch();
    end_sim();
  end
endmodule // test_fixed_ratio_pll_core

`default_nettype wire
